// ### common/dpc_pkg.sv
package dpc_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int DPC_CHANNELS = 2;
    localparam int DPC_COUNT_W = 8;
    localparam int DPC_SUB_W = 2;
    localparam int DPC_DUTY_W = 10;
    localparam int DPC_ADDR_W = 5;
    localparam int DPC_DATA_W = 32;
    localparam int DPC_BE_W = 4;

    // ----------------------------------------------------------------
    // Register byte offsets, one word per register, index is channel
    // ----------------------------------------------------------------
    localparam logic [1:0][4:0] DPC_OFS_CTRL = {5'h0C, 5'h00};
    localparam logic [1:0][4:0] DPC_OFS_DHI = {5'h10, 5'h04};
    localparam logic [1:0][4:0] DPC_OFS_DLO = {5'h14, 5'h08};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DPC_BIT_RUN = 7;
    localparam int DPC_BIT_PIN = 6;
    localparam int DPC_BIT_LEVEL = 5;
    localparam int DPC_BIT_INV = 4;
    localparam int DPC_DLO_MSB = 7;
    localparam int DPC_DLO_LSB = 6;
    localparam int DPC_BE_LANE0 = 0;

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam logic [DPC_COUNT_W-1:0] DPC_COUNT_ZERO = 8'h00;
    localparam logic [DPC_SUB_W-1:0] DPC_SUB_ZERO = 2'h0;
    localparam logic [DPC_SUB_W-1:0] DPC_SUB_STEP = 2'h1;
    localparam logic [DPC_DUTY_W-1:0] DPC_DUTY_ZERO = 10'h000;
    localparam logic [DPC_DUTY_W:0] DPC_QUAD_STEP = 11'h004;
    localparam logic [DPC_DATA_W-1:0] DPC_RDATA_ZERO = 32'h00000000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DPC_BUS_IDLE = 2'b01,
        DPC_BUS_ACK = 2'b10
    } dpc_bus_e_t;

    typedef struct packed {
        logic [DPC_COUNT_W-1:0] count;
        logic [DPC_COUNT_W-1:0] limit;
        logic tick;
    } dpc_timer_t;

    typedef struct packed {
        logic [DPC_CHANNELS-1:0] drive;
        logic [DPC_CHANNELS-1:0] enable;
    } dpc_pins_t;

    typedef struct packed {
        dpc_bus_e_t bus;
        logic waitReq;
        logic [DPC_DATA_W-1:0] rdata;
        logic [DPC_CHANNELS-1:0] runEnable;
        logic [DPC_CHANNELS-1:0] pinDriveEnable;
        logic [DPC_CHANNELS-1:0] invertSelect;
        logic [DPC_CHANNELS-1:0][7:0] dutyHigh;
        logic [DPC_CHANNELS-1:0][1:0] dutyLow;
        logic [DPC_CHANNELS-1:0][DPC_DUTY_W-1:0] dutyBuf;
        logic [DPC_CHANNELS-1:0] raw;
        logic [DPC_CHANNELS-1:0] level;
        dpc_pins_t pins;
        logic [DPC_SUB_W-1:0] sub;
        logic [DPC_COUNT_W-1:0] prevCount;
    } dpc_state_t;

endpackage

// ### hdl/dpc_pwm.sv
`timescale 1ns/1ps

// Summary of operation
// R01: Channel modulates only while its run enable bit 7 is one.
// R02: Pin is driven with the waveform only while pin drive enable bit 6 is one.
// R03: Bit 5 reads back the output level, ignores writes, is zero after reset.
// R04: Polarity bit 4 zero gives active-high output, one gives inverted output.
// R05: Control bits 3 to 0 read zero and ignore writes.
// R06: Duty high register supplies the eight upper duty bits.
// R07: Duty low bits 7:6 give the two lower duty bits; others read zero.
// R08: All implemented control bits clear on every reset.
// R09: Duty high and low registers keep their contents through reset.
// R10: Output sets when the period counter clears, clears on time base match.
// R11: Duty at or beyond the full period never clears the output.
// R12: Duty registers are copied into the compare buffer only at period wrap.
// R13: Time base is the period counter extended by two prescaled-clock bits.
// R14: Two independent channels share one period counter and period limit.
// R15: A disabled channel sits at its inactive level, shown on readback.
module dpc_pwm (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [dpc_pkg::DPC_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [dpc_pkg::DPC_BE_W-1:0] byteenable,
    input wire logic [dpc_pkg::DPC_DATA_W-1:0] writedata,
    output logic [dpc_pkg::DPC_DATA_W-1:0] readdata,
    output logic waitrequest,
    // Shared period counter and limit
    input wire dpc_pkg::dpc_timer_t timer,
    // Channel pins
    output dpc_pkg::dpc_pins_t pins
);
    import dpc_pkg::*;

    dpc_state_t state_q;
    dpc_state_t state_d;
    logic busAck;
    logic regWrite;
    logic wrap;
    logic [DPC_SUB_W-1:0] tickStep;
    logic [DPC_SUB_W-1:0] subNext;
    logic [DPC_DUTY_W:0] periodQuads;
    logic [DPC_DUTY_W-1:0] timeBase;
    logic [DPC_CHANNELS-1:0] runNext;
    logic [DPC_CHANNELS-1:0] pinNext;
    logic [DPC_CHANNELS-1:0] invNext;
    logic [DPC_CHANNELS-1:0][7:0] dutyHighNext;
    logic [DPC_CHANNELS-1:0][1:0] dutyLowNext;
    logic [DPC_CHANNELS-1:0][DPC_DUTY_W-1:0] dutyBufNext;
    logic [DPC_CHANNELS-1:0] rawNext;
    logic [DPC_CHANNELS-1:0] levelNext;
    logic [DPC_CHANNELS-1:0] driveNext;
    logic [DPC_CHANNELS-1:0] enableNext;

    // ----------------------------------------------------------------
    // Write strobe
    // ----------------------------------------------------------------
    // Writes commit on the edge that completes the transfer, so a
    // request held during the wait cycle is applied only once.
    assign busAck = state_q.bus == DPC_BUS_ACK;
    assign regWrite = busAck && write && byteenable[DPC_BE_LANE0];

    // ----------------------------------------------------------------
    // Shared time base
    // ----------------------------------------------------------------
    // Wrap is seen as the counter landing on zero from a nonzero
    // value; a limit of zero therefore never produces a wrap.
    assign wrap = (timer.count == DPC_COUNT_ZERO)
        && (state_q.prevCount != DPC_COUNT_ZERO); // R14
    assign tickStep = state_q.sub + DPC_SUB_STEP;
    assign subNext = wrap ? DPC_SUB_ZERO : (timer.tick ? tickStep : state_q.sub); // R13
    assign timeBase = {timer.count, subNext}; // R13
    assign periodQuads = {1'b0, timer.limit, DPC_SUB_ZERO} + DPC_QUAD_STEP;

    // ----------------------------------------------------------------
    // Channel lanes
    // ----------------------------------------------------------------
    // Both lanes depend only on registered state, bus and timer inputs, so no
    // combinational path loops back through the next-state process.
    for (genvar ch = 0; ch < DPC_CHANNELS; ch++) begin : g_chan
        dpc_reg_lane #(
            .CTRL_OFS(DPC_OFS_CTRL[ch]),
            .DHI_OFS(DPC_OFS_DHI[ch]),
            .DLO_OFS(DPC_OFS_DLO[ch])
        ) regs (
            .regWrite(regWrite),
            .address(address),
            .wrByte(writedata[7:0]),
            .runCur(state_q.runEnable[ch]),
            .pinCur(state_q.pinDriveEnable[ch]),
            .invCur(state_q.invertSelect[ch]),
            .dutyHighCur(state_q.dutyHigh[ch]),
            .dutyLowCur(state_q.dutyLow[ch]),
            .runNext(runNext[ch]),
            .pinNext(pinNext[ch]),
            .invNext(invNext[ch]),
            .dutyHighNext(dutyHighNext[ch]),
            .dutyLowNext(dutyLowNext[ch])
        );

        dpc_wave_lane wave (
            .wrap(wrap),
            .timeBase(timeBase),
            .periodQuads(periodQuads),
            .run(runNext[ch]),
            .invert(invNext[ch]),
            .pin(pinNext[ch]),
            .dutyHigh(dutyHighNext[ch]),
            .dutyLow(dutyLowNext[ch]),
            .dutyBufCur(state_q.dutyBuf[ch]),
            .rawCur(state_q.raw[ch]),
            .dutyBufNext(dutyBufNext[ch]),
            .rawNext(rawNext[ch]),
            .levelNext(levelNext[ch]),
            .driveNext(driveNext[ch]),
            .enableNext(enableNext[ch])
        ); // R14
    end

    // ----------------------------------------------------------------
    // Register read mux
    // ----------------------------------------------------------------
    function automatic logic [DPC_DATA_W-1:0] readReg(
        input logic [DPC_ADDR_W-1:0] a,
        input dpc_state_t q
    );
        logic [DPC_DATA_W-1:0] r;
        r = DPC_RDATA_ZERO;
        for (int ch = 0; ch < DPC_CHANNELS; ch++) begin
            if (a == DPC_OFS_CTRL[ch]) begin
                // Low nibble stays zero
                r[DPC_BIT_RUN] = q.runEnable[ch]; // R05
                r[DPC_BIT_PIN] = q.pinDriveEnable[ch];
                r[DPC_BIT_LEVEL] = q.level[ch]; // R03
                r[DPC_BIT_INV] = q.invertSelect[ch];
            end
            if (a == DPC_OFS_DHI[ch]) begin
                r[7:0] = q.dutyHigh[ch]; // R06
            end
            if (a == DPC_OFS_DLO[ch]) begin
                r[DPC_DLO_MSB:DPC_DLO_LSB] = q.dutyLow[ch]; // R07
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_d = state_q;

        // Bus: one wait cycle, then a single cycle with waitrequest low.
        case (state_q.bus)
            DPC_BUS_IDLE: begin
                if (read || write) begin
                    state_d.bus = DPC_BUS_ACK;
                    state_d.waitReq = 1'b0;
                    state_d.rdata = read ? readReg(address, state_q) : DPC_RDATA_ZERO;
                end
            end
            DPC_BUS_ACK: begin
                state_d.bus = DPC_BUS_IDLE;
                state_d.waitReq = 1'b1;
                state_d.rdata = DPC_RDATA_ZERO;
            end
            default: begin
                state_d.bus = DPC_BUS_IDLE;
                state_d.waitReq = 1'b1;
                state_d.rdata = DPC_RDATA_ZERO;
            end
        endcase

        // ------------------------------------------------------------
        // Registers and waveform from the lanes
        // ------------------------------------------------------------
        state_d.runEnable = runNext; // R01
        state_d.pinDriveEnable = pinNext; // R02
        state_d.invertSelect = invNext; // R04
        state_d.dutyHigh = dutyHighNext; // R06
        state_d.dutyLow = dutyLowNext; // R07
        state_d.dutyBuf = dutyBufNext; // R12
        state_d.raw = rawNext; // R10
        state_d.level = levelNext; // R03
        state_d.pins.drive = driveNext; // R02
        state_d.pins.enable = enableNext; // R02
        state_d.sub = subNext; // R13
        state_d.prevCount = timer.count;

        // ------------------------------------------------------------
        // Reset: duty registers ride through, waitrequest rises, everything else clears
        // ------------------------------------------------------------
        if (reset) begin
            state_d.bus = DPC_BUS_IDLE;
            state_d.waitReq = 1'b1;
            state_d.rdata = DPC_RDATA_ZERO;
            state_d.runEnable = '0; // R08
            state_d.pinDriveEnable = '0; // R08
            state_d.invertSelect = '0; // R08
            state_d.dutyHigh = state_q.dutyHigh; // R09
            state_d.dutyLow = state_q.dutyLow; // R09
            state_d.dutyBuf = '0;
            state_d.raw = '0;
            state_d.level = '0; // R03
            state_d.pins = '0;
            state_d.sub = DPC_SUB_ZERO;
            state_d.prevCount = DPC_COUNT_ZERO;
        end
    end

    always_ff @(posedge mclk) begin
        state_q <= state_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign readdata = state_q.rdata;
    assign waitrequest = state_q.waitReq;
    assign pins = state_q.pins;

endmodule

// ----------------------------------------------------------------
// Register lane: one channel's control and duty registers
// ----------------------------------------------------------------
module dpc_reg_lane #(
    parameter logic [dpc_pkg::DPC_ADDR_W-1:0] CTRL_OFS = '0,
    parameter logic [dpc_pkg::DPC_ADDR_W-1:0] DHI_OFS = '0,
    parameter logic [dpc_pkg::DPC_ADDR_W-1:0] DLO_OFS = '0
) (
    // Completed write on the register bus
    input wire logic regWrite,
    input wire logic [dpc_pkg::DPC_ADDR_W-1:0] address,
    input wire logic [7:0] wrByte,
    // Register contents now
    input wire logic runCur,
    input wire logic pinCur,
    input wire logic invCur,
    input wire logic [7:0] dutyHighCur,
    input wire logic [1:0] dutyLowCur,
    // Register contents after this edge
    output logic runNext,
    output logic pinNext,
    output logic invNext,
    output logic [7:0] dutyHighNext,
    output logic [1:0] dutyLowNext
);
    import dpc_pkg::*;

    logic ctrlHit;
    logic dhiHit;
    logic dloHit;

    assign ctrlHit = regWrite && (address == CTRL_OFS);
    assign dhiHit = regWrite && (address == DHI_OFS);
    assign dloHit = regWrite && (address == DLO_OFS);

    always_comb begin
        runNext = runCur;
        pinNext = pinCur;
        invNext = invCur;
        dutyHighNext = dutyHighCur;
        dutyLowNext = dutyLowCur;
        if (ctrlHit) begin
            // Readback bit and low nibble are not stored
            runNext = wrByte[DPC_BIT_RUN]; // R03 R05
            pinNext = wrByte[DPC_BIT_PIN]; // R02
            invNext = wrByte[DPC_BIT_INV]; // R04
        end
        if (dhiHit) begin
            dutyHighNext = wrByte; // R06
        end
        if (dloHit) begin
            dutyLowNext = wrByte[DPC_DLO_MSB:DPC_DLO_LSB]; // R07
        end
    end

endmodule

// ----------------------------------------------------------------
// Waveform lane: duty buffer, set and clear of one channel
// ----------------------------------------------------------------
// The duty pair is only sampled at wrap; software that writes one
// half late gets a mixed value for a whole period.
module dpc_wave_lane #(
    parameter int HI_W = 8,
    parameter int LO_W = 2,
    parameter int DUTY_W = HI_W + LO_W
) (
    // Shared time base
    input wire logic wrap,
    input wire logic [DUTY_W-1:0] timeBase,
    input wire logic [DUTY_W:0] periodQuads,
    // Channel settings after any write at this edge
    input wire logic run,
    input wire logic invert,
    input wire logic pin,
    input wire logic [HI_W-1:0] dutyHigh,
    input wire logic [LO_W-1:0] dutyLow,
    // Current waveform state
    input wire logic [DUTY_W-1:0] dutyBufCur,
    input wire logic rawCur,
    // Next waveform state
    output logic [DUTY_W-1:0] dutyBufNext,
    output logic rawNext,
    output logic levelNext,
    output logic driveNext,
    output logic enableNext
);
    import dpc_pkg::*;

    logic [DUTY_W-1:0] loadValue;
    logic fullDuty;
    logic baseMatch;

    assign loadValue = {dutyHigh, dutyLow};

    always_comb begin
        dutyBufNext = dutyBufCur;
        rawNext = rawCur;
        if (wrap) begin
            dutyBufNext = loadValue; // R12
        end
        fullDuty = {1'b0, dutyBufNext} >= periodQuads; // R11
        baseMatch = timeBase == dutyBufNext; // R10
        if (!run) begin
            rawNext = 1'b0; // R01 R15
        end else if (wrap) begin
            // Zero duty stays inactive through the wrap
            rawNext = dutyBufNext != '0; // R10
        end else if (baseMatch && !fullDuty) begin
            rawNext = 1'b0; // R10 R11
        end
        levelNext = rawNext ^ invert; // R04 R15
        driveNext = pin & levelNext; // R02
        enableNext = pin; // R02
    end

endmodule

// ### verification/dpc_load.sv
`timescale 1ns/1ps
module dpc_load (
    // Clock
    input wire logic mclk,
    // Pins and window control
    input wire dpc_pkg::dpc_pins_t pins,
    input wire logic clr,
    output logic [1:0][7:0] hiCnt
);
    import dpc_pkg::*;
    logic [1:0] lvl;
    // A pull-down holds a released pin low
    assign lvl = pins.drive & pins.enable;
    always_ff @(posedge mclk) begin
        for (int i = 0; i < 2; i++) begin
            hiCnt[i] <= clr ? 8'h00 : hiCnt[i] + {7'h00, lvl[i]};
        end
    end
endmodule

// ### verification/dpc_pwm_chk.sv
`timescale 1ns/1ps
module dpc_pwm_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Register bus
    input wire logic [dpc_pkg::DPC_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [dpc_pkg::DPC_BE_W-1:0] byteenable,
    input wire logic [dpc_pkg::DPC_DATA_W-1:0] writedata,
    input wire logic [dpc_pkg::DPC_DATA_W-1:0] readdata,
    input wire logic waitrequest,
    // Timer and pins
    input wire dpc_pkg::dpc_timer_t timer,
    input wire dpc_pkg::dpc_pins_t pins
);
    import dpc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_take; (read || write) && waitrequest; endsequence
    sequence s_done; !waitrequest ##1 waitrequest; endsequence
    a_bus_answer: assert property (s_take |=> s_done) else $error("bus answer late");
    a_idle_data: assert property (waitrequest |-> readdata == DPC_RDATA_ZERO)
        else $error("read data outside answer");
    a_upper_zero: assert property (readdata[31:8] == 24'h000000) else $error("upper bits set");
    a_ctrl_unimpl: assert property (read && waitrequest && (address == 5'h00 || address == 5'h0C)
        |=> readdata[3:0] == 4'h0) else $error("control low bits set");
    a_dlo_unimpl: assert property (read && waitrequest && (address == 5'h08 || address == 5'h14)
        |=> readdata[5:0] == 6'h00) else $error("duty low bits set");
    a_map_hole: assert property (read && waitrequest && address >= 5'h18 |=> readdata == '0)
        else $error("unmapped read not zero");
    a_pin_release: assert property ((pins.drive & ~pins.enable) == 2'b00)
        else $error("released pin driven");
    a_reset_idle: assert property ($fell(reset) |-> pins == '0 && waitrequest)
        else $error("reset state wrong");
endmodule
bind dpc_pwm dpc_pwm_chk chk (.mclk(mclk), .reset(reset), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .timer(timer), .pins(pins));

// ### verification/tb_dual_pwm_control_regs.sv
`timescale 1ns/1ps
module tb_dual_pwm_control_regs;
    import dpc_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [DPC_ADDR_W-1:0] address = '0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [DPC_BE_W-1:0] byteenable = 4'hF;
    logic [DPC_DATA_W-1:0] writedata = '0;
    logic [DPC_DATA_W-1:0] readdata;
    logic waitrequest;
    dpc_timer_t timer;
    dpc_pins_t pins;
    logic clr = 1'b1;
    logic [1:0][7:0] hiCnt;
    logic [1:0] pre = 2'h0;
    logic [7:0] cnt = 8'h00;
    logic [7:0] r;
    logic [31:0] expQ [$];
    int mismatches = 0;
    int checked = 0;
    always #2.5 mclk = ~mclk;
    assign timer = '{count: cnt, limit: 8'h03, tick: 1'b1};
    dpc_pwm dut (.mclk(mclk), .reset(reset), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .timer(timer), .pins(pins));
    dpc_load load (.mclk(mclk), .pins(pins), .clr(clr), .hiCnt(hiCnt));
    // Shared timer stand-in: period of 16 cycles
    always @(posedge mclk) begin
        pre <= pre + 2'h1;
        if (pre == 2'h3) cnt <= (cnt == 8'h03) ? 8'h00 : cnt + 8'h01;
    end
    task close_out;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task fail(input string m);
        mismatches++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge mclk);
        write <= w;
        read <= !w;
        address <= a;
        writedata <= {24'h000000, d};
        if (!w) expQ.push_back({24'h000000, e});
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            fail("bus timeout");
            close_out();
        end
    endtask
    // Edge jitter of one cycle at set and clear is tolerated on channel 0
    task meas(input logic [7:0] e0, input logic [7:0] e1);
        clr <= 1'b0;
        repeat (33) @(posedge mclk);
        clr <= 1'b1;
        checked++;
        if (hiCnt[0] + 8'h02 < e0 || hiCnt[0] > e0 + 8'h02 || hiCnt[1] !== e1) fail("pin duty");
    endtask
    always @(posedge mclk) begin
        if (read && waitrequest === 1'b0) begin
            checked++;
            if (expQ.size() == 0 || readdata !== expQ.pop_front()) fail("read data");
        end
    end
    initial begin
        repeat (20000) @(posedge mclk);
        fail("run timeout");
        close_out();
    end
    initial begin
        void'($urandom(57086));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        for (int c = 0; c < 2; c++) begin
            bus(1'b0, DPC_OFS_CTRL[c], 8'h00, 8'h00);
            repeat (3) begin
                r = 8'($urandom) & 8'h7F;
                bus(1'b1, DPC_OFS_CTRL[c], r, 8'h00);
                bus(1'b0, DPC_OFS_CTRL[c], 8'h00, (r & 8'h50) | {2'b00, r[4], 5'h00});
                r = 8'($urandom);
                bus(1'b1, DPC_OFS_DHI[c], r, 8'h00);
                bus(1'b0, DPC_OFS_DHI[c], 8'h00, r);
                bus(1'b1, DPC_OFS_DLO[c], ~r, 8'h00);
                bus(1'b0, DPC_OFS_DLO[c], 8'h00, ~r & 8'hC0);
            end
        end
        bus(1'b1, 5'h18, 8'hFF, 8'h00);
        bus(1'b0, 5'h18, 8'h00, 8'h00);
        bus(1'b1, DPC_OFS_DHI[0], 8'h01, 8'h00);
        bus(1'b1, DPC_OFS_DLO[0], 8'h80, 8'h00);
        bus(1'b1, DPC_OFS_DHI[1], 8'h04, 8'h00);
        bus(1'b1, DPC_OFS_DLO[1], 8'h00, 8'h00);
        bus(1'b1, DPC_OFS_CTRL[0], 8'hC0, 8'h00);
        bus(1'b1, DPC_OFS_CTRL[1], 8'hC0, 8'h00);
        repeat (20) @(posedge mclk);
        meas(8'h0C, 8'h20);
        bus(1'b1, DPC_OFS_CTRL[0], 8'hD0, 8'h00);
        bus(1'b1, DPC_OFS_CTRL[1], 8'h40, 8'h00);
        repeat (20) @(posedge mclk);
        meas(8'h14, 8'h00);
        byteenable <= 4'h0;
        bus(1'b1, DPC_OFS_DHI[0], 8'hAA, 8'h00);
        byteenable <= 4'hF;
        bus(1'b0, DPC_OFS_DHI[0], 8'h00, 8'h01);
        bus(1'b1, DPC_OFS_CTRL[0], 8'h90, 8'h00);
        repeat (2) @(posedge mclk);
        checked++;
        if (pins.enable !== 2'b10 || pins.drive !== 2'b00) fail("pin release");
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        bus(1'b0, DPC_OFS_DHI[0], 8'h00, 8'h01);
        bus(1'b0, DPC_OFS_CTRL[1], 8'h00, 8'h00);
        repeat (3) @(posedge mclk);
        close_out();
    end
endmodule
